// >>> shared/port_phy_defines.svh
// register offsets, field positions and reset values of the port phy control block
`ifndef PORT_PHY_DEFINES_SVH
`define PORT_PHY_DEFINES_SVH
// word indices on the bus; byte address is four times the index
`define PPC_IDX 6'h02
`define STD_CTRL_IDX 6'h04
`define STD_ADV_IDX 6'h05
`define LINK_STATE_IDX 6'h06
`define PPC_RESET 16'h009F
// port_phy_control fields
`define F_LED_OFF 15
`define F_TX_DIS 14
`define F_AN_RESTART 13
`define F_RSVD12 12
`define F_PWR_DOWN 11
`define F_MDIX_DIS 10
`define F_FORCE_MDIX 9
`define F_RSVD8 8
`define F_AN_EN 7
`define F_FORCE_SPD 6
`define F_FORCE_DUP 5
`define F_ADV_PAUSE 4
// standard control view fields
`define S_LED_OFF 0
`define S_TX_DIS 1
`define S_RSVD 2
`define S_MDIX_DIS 3
`define S_FORCE_MDIX 4
`define S_FORCE_DUP 8
`define S_AN_RESTART 9
`define S_PWR_DOWN 11
`define S_AN_EN 12
`define S_FORCE_SPD 13
// standard advertisement view: pause at 10, four speed caps at 8..5
`define S_ADV_PAUSE 10
`define S_ADV_CAP_LSB 5
`endif

// >>> shared/port_phy_pkg.sv
// types shared by the port phy control block
package port_phy_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [3:0] led_vec_t;
  typedef enum logic {bus_idle, bus_ack} bus_state_t;
endpackage

// >>> hdl/link_resolve.sv
// resolves link speed, duplex and crossover from control bits and phy results
`timescale 1ns/100ps
`default_nettype none
module link_resolve (
  input wire logic an_en,
  input wire logic force_spd,
  input wire logic force_dup,
  input wire logic an_fail,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic mdix_dis,
  input wire logic force_mdix,
  input wire logic auto_mdix_sel,
  output logic speed_100,
  output logic full_duplex,
  output logic mdix
);
  always_comb begin
    speed_100 = an_en ? an_speed_100 : force_spd;
    // forced duplex also covers a failed negotiation
    full_duplex = (an_en && !an_fail) ? an_full_duplex : force_dup;
    // manual crossover only when auto is off
    mdix = mdix_dis ? force_mdix : auto_mdix_sel;
  end
endmodule // link_resolve
`default_nettype wire

// >>> hdl/port_phy_ctrl.sv
// per-port phy control register with avalon-mm slave and phy/led outputs
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "port_phy_defines.svh"
module port_phy_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire port_phy_pkg::led_vec_t led_norm,
  input wire logic an_done,
  input wire logic an_fail,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic auto_mdix_sel,
  output logic port_led_out_3,
  output logic port_led_out_2,
  output logic port_led_out_1,
  output logic port_led_out_0,
  output logic tx_disable,
  output logic an_restart,
  output logic power_down,
  output logic auto_mdix_en,
  output logic mdix_mode,
  output logic an_enable,
  output logic speed_100,
  output logic full_duplex,
  output logic adv_pause,
  output logic [3:0] adv_caps
);
  import port_phy_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // view mapping functions

  function automatic reg16_t merge16(reg16_t old, logic [31:0] wd, logic [3:0] be);
    reg16_t r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic reg16_t to_std(reg16_t c);
    reg16_t s;
    s = 16'h0000;
    s[`S_LED_OFF] = c[`F_LED_OFF];
    s[`S_TX_DIS] = c[`F_TX_DIS];
    s[`S_RSVD] = c[`F_RSVD12];
    s[`S_MDIX_DIS] = c[`F_MDIX_DIS];
    s[`S_FORCE_MDIX] = c[`F_FORCE_MDIX];
    s[`S_FORCE_DUP] = c[`F_FORCE_DUP];
    s[`S_AN_RESTART] = c[`F_AN_RESTART];
    s[`S_PWR_DOWN] = c[`F_PWR_DOWN];
    s[`S_AN_EN] = c[`F_AN_EN];
    s[`S_FORCE_SPD] = c[`F_FORCE_SPD];
    return s;
  endfunction

  function automatic reg16_t from_std(reg16_t s, reg16_t c);
    reg16_t r;
    r = c;
    r[`F_LED_OFF] = s[`S_LED_OFF];
    r[`F_TX_DIS] = s[`S_TX_DIS];
    r[`F_RSVD12] = s[`S_RSVD];
    r[`F_MDIX_DIS] = s[`S_MDIX_DIS];
    r[`F_FORCE_MDIX] = s[`S_FORCE_MDIX];
    r[`F_FORCE_DUP] = s[`S_FORCE_DUP];
    r[`F_AN_RESTART] = s[`S_AN_RESTART];
    r[`F_PWR_DOWN] = s[`S_PWR_DOWN];
    r[`F_AN_EN] = s[`S_AN_EN];
    r[`F_FORCE_SPD] = s[`S_FORCE_SPD];
    return r;
  endfunction

  function automatic reg16_t to_adv(reg16_t c);
    reg16_t a;
    a = 16'h0000;
    a[`S_ADV_PAUSE] = c[`F_ADV_PAUSE];
    a[`S_ADV_CAP_LSB +: 4] = c[3:0];
    return a;
  endfunction

  function automatic reg16_t from_adv(reg16_t a, reg16_t c);
    reg16_t r;
    r = c;
    r[`F_ADV_PAUSE] = a[`S_ADV_PAUSE];
    r[3:0] = a[`S_ADV_CAP_LSB +: 4];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then a one-cycle answer

  bus_state_t bus_state_q;
  logic [5:0] idx;
  logic wr_go;
  logic rd_go;
  reg16_t ctrl_q;
  reg16_t ctrl_d;
  reg16_t rd_d;
  logic res_speed;
  logic res_duplex;
  logic res_mdix;

  assign idx = avs_address[7:2];
  // a write lands at the very edge the master sees waitrequest low
  assign wr_go = avs_write && (bus_state_q == bus_ack);
  assign rd_go = avs_read && (bus_state_q == bus_idle);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_q <= bus_idle;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state_q)
        bus_idle: begin
          if (avs_read || avs_write) begin
            bus_state_q <= bus_ack;
            avs_waitrequest <= 1'b0;
          end
        end
        bus_ack: begin
          bus_state_q <= bus_idle;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_q <= bus_idle;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read data is sampled on entry to the answer cycle and stands through it
  always_comb begin
    case (idx)
      `PPC_IDX: rd_d = ctrl_q;
      `STD_CTRL_IDX: rd_d = to_std(ctrl_q);
      `STD_ADV_IDX: rd_d = to_adv(ctrl_q);
      `LINK_STATE_IDX: rd_d = {11'h000, an_done, an_fail, speed_100, full_duplex, mdix_mode};
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= {16'h0000, rd_d};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control storage, one set of flops behind all three views

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_go) begin
      case (idx)
        `PPC_IDX: ctrl_d = merge16(ctrl_q, avs_writedata, avs_byteenable);
        // the standard views write through to the same flops
        `STD_CTRL_IDX: ctrl_d = from_std(merge16(to_std(ctrl_q), avs_writedata, avs_byteenable), ctrl_q);
        `STD_ADV_IDX: ctrl_d = from_adv(merge16(to_adv(ctrl_q), avs_writedata, avs_byteenable), ctrl_q);
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `PPC_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // restart request: pulse per write of one, the stored bit only reads back

  logic restart_wr;
  assign restart_wr = wr_go && (ctrl_d[`F_AN_RESTART] == 1'b1) &&
                      ((idx == `PPC_IDX && avs_byteenable[1]) ||
                       (idx == `STD_CTRL_IDX && avs_byteenable[1]));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= restart_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // led blanking

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      port_led_out_3 <= 1'b1;
      port_led_out_2 <= 1'b1;
      port_led_out_1 <= 1'b1;
      port_led_out_0 <= 1'b1;
    end else begin
      // leds are active low, so blanking means driving high
      port_led_out_3 <= ctrl_q[`F_LED_OFF] | led_norm[3];
      port_led_out_2 <= ctrl_q[`F_LED_OFF] | led_norm[2];
      port_led_out_1 <= ctrl_q[`F_LED_OFF] | led_norm[1];
      port_led_out_0 <= ctrl_q[`F_LED_OFF] | led_norm[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phy controls and advertisement

  link_resolve u_resolve (
    .an_en(ctrl_q[`F_AN_EN]),
    .force_spd(ctrl_q[`F_FORCE_SPD]),
    .force_dup(ctrl_q[`F_FORCE_DUP]),
    .an_fail(an_fail),
    .an_speed_100(an_speed_100),
    .an_full_duplex(an_full_duplex),
    .mdix_dis(ctrl_q[`F_MDIX_DIS]),
    .force_mdix(ctrl_q[`F_FORCE_MDIX]),
    .auto_mdix_sel(auto_mdix_sel),
    .speed_100(res_speed),
    .full_duplex(res_duplex),
    .mdix(res_mdix)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_disable <= 1'b0;
      power_down <= 1'b0;
      auto_mdix_en <= 1'b1;
      mdix_mode <= 1'b0;
      an_enable <= 1'b1;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      tx_disable <= ctrl_q[`F_TX_DIS];
      power_down <= ctrl_q[`F_PWR_DOWN];
      auto_mdix_en <= !ctrl_q[`F_MDIX_DIS];
      mdix_mode <= res_mdix;
      an_enable <= ctrl_q[`F_AN_EN];
      speed_100 <= res_speed;
      full_duplex <= res_duplex;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adv_pause <= 1'b1;
      adv_caps <= 4'hF;
    end else begin
      adv_pause <= ctrl_q[`F_ADV_PAUSE];
      adv_caps <= ctrl_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_req_idle;
    (avs_read || avs_write) && bus_state_q == bus_idle;
  endsequence

  sequence s_one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (s_req_idle |=> s_one_answer)
    else $error("bus answer not one cycle after request");

  a_led_blank: assert property (ctrl_q[`F_LED_OFF] |=>
    {port_led_out_3, port_led_out_2, port_led_out_1, port_led_out_0} == 4'hF)
    else $error("leds not blanked");

  a_tx_disable: assert property (ctrl_q[`F_TX_DIS] != tx_disable |=>
    tx_disable == $past(ctrl_q[`F_TX_DIS]))
    else $error("transmitter disable does not follow control");

  sequence s_restart_wr;
    restart_wr ##1 an_restart;
  endsequence

  a_restart_pulse: assert property (s_restart_wr |=> !an_restart)
    else $error("restart not a single pulse");

  a_auto_mdix: assert property (!ctrl_q[`F_MDIX_DIS] |=> auto_mdix_en)
    else $error("auto crossover not active");

  a_force_mdix: assert property (ctrl_q[`F_MDIX_DIS] && ctrl_q[`F_FORCE_MDIX] |=> mdix_mode)
    else $error("mdi-x not forced");

  a_forced_speed: assert property (!ctrl_q[`F_AN_EN] |=>
    !an_enable && speed_100 == $past(ctrl_q[`F_FORCE_SPD]))
    else $error("forced speed not applied");

  a_forced_duplex: assert property (!ctrl_q[`F_AN_EN] || an_fail |=>
    full_duplex == $past(ctrl_q[`F_FORCE_DUP]))
    else $error("forced duplex not applied");

  a_adv_bits: assert property (ctrl_q[4:0] != {adv_pause, adv_caps} |=>
    {adv_pause, adv_caps} == $past(ctrl_q[4:0]))
    else $error("advertisement does not follow control");

  a_power_down: assert property ($rose(ctrl_q[`F_PWR_DOWN]) |=> power_down)
    else $error("power down not applied");

  a_alias_view: assert property (wr_go && idx == `STD_CTRL_IDX && avs_byteenable[1] |=>
    ctrl_q[`F_PWR_DOWN] == $past(avs_writedata[`S_PWR_DOWN]))
    else $error("standard view write lost");

endmodule // port_phy_ctrl
`default_nettype wire

// >>> test/port_phy_ctrl_tb.sv
// self-checking bench for the port phy control register
`timescale 1ns/100ps
`default_nettype none
module port_phy_ctrl_tb;
  import port_phy_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  led_vec_t led_norm = 4'h0;
  logic an_done = 1'b0;
  logic an_fail = 1'b0;
  logic an_speed_100 = 1'b0;
  logic an_full_duplex = 1'b0;
  logic auto_mdix_sel = 1'b0;
  wire [3:0] leds;
  logic tx_disable, an_restart, power_down, auto_mdix_en, mdix_mode, an_enable;
  logic speed_100, full_duplex, adv_pause;
  logic [3:0] adv_caps;
  int n_fail = 0;
  int num_checks = 0;
  int n_pulse = 0;
  int p0;
  logic [15:0] lfsr = 16'hE48F;
  reg16_t ctl;
  logic [31:0] q;
  int i;
  logic [3:0] be;
  ////////////////////////////////////////////////////////////////////////////
  port_phy_ctrl i_port_phy_ctrl (
    .sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .led_norm, .an_done,
    .an_fail, .an_speed_100, .an_full_duplex, .auto_mdix_sel,
    .port_led_out_3(leds[3]), .port_led_out_2(leds[2]),
    .port_led_out_1(leds[1]), .port_led_out_0(leds[0]),
    .tx_disable, .an_restart, .power_down, .auto_mdix_en, .mdix_mode,
    .an_enable, .speed_100, .full_duplex, .adv_pause, .adv_caps
  );
  always #10 sys_clk = ~sys_clk;
  // counted on the falling edge so a pulse is never raced at the rising one
  always @(negedge sys_clk) begin
    if (an_restart === 1'b1) n_pulse++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] step(input logic [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] std_view(input reg16_t c);
    std_view = 32'h0000_0000;
    std_view[4:0] = {c[9], c[10], c[12], c[14], c[15]};
    std_view[13:8] = {c[6], c[7], c[11], 1'b0, c[13], c[5]};
  endfunction
  function automatic logic [31:0] adv_view(input reg16_t c);
    adv_view = {21'h00_0000, c[4], 1'b0, c[3:0], 5'h00};
  endfunction
  // one request, held until waitrequest is seen low; the bench is entered just after an edge
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] b);
    int k;
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= b;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 20) begin
      n_fail++;
      results();
    end
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0000_0000, 4'hF);
    chk("readdata", e, q);
  endtask
  task automatic chk_out(input int p0, input int np);
    logic m;
    @(negedge sys_clk);
    @(negedge sys_clk);
    m = ctl[10] ? ctl[9] : auto_mdix_sel;
    chk("leds", {28'h000_0000, led_norm | {4{ctl[15]}}}, {28'h000_0000, leds});
    chk("tx_disable", {31'h0, ctl[14]}, {31'h0, tx_disable});
    chk("an_restart pulses", np, n_pulse - p0);
    chk("auto_mdix_en", {31'h0, !ctl[10]}, {31'h0, auto_mdix_en});
    chk("mdix_mode", {31'h0, m}, {31'h0, mdix_mode});
    chk("an_enable", {31'h0, ctl[7]}, {31'h0, an_enable});
    chk("speed_100", {31'h0, ctl[7] ? an_speed_100 : ctl[6]}, {31'h0, speed_100});
    chk("full_duplex", {31'h0, (ctl[7] && !an_fail) ? an_full_duplex : ctl[5]}, {31'h0, full_duplex});
    chk("adv_pause", {31'h0, ctl[4]}, {31'h0, adv_pause});
    chk("adv_caps", {28'h000_0000, ctl[3:0]}, {28'h000_0000, adv_caps});
    chk("power_down", {31'h0, ctl[11]}, {31'h0, power_down});
    @(posedge sys_clk);
  endtask
  task automatic views();
    rd(6'h02, {16'h0000, ctl});
    rd(6'h04, std_view(ctl));
    rd(6'h05, adv_view(ctl));
    rd(6'h06, {27'h0, an_done, an_fail, speed_100, full_duplex, mdix_mode});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    ctl = 16'h009F;
    chk_out(n_pulse, 0);
    views();
    // random writes, with lane 1 sometimes masked off
    for (i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      led_norm <= lfsr[3:0];
      {an_done, an_fail, an_speed_100, an_full_duplex, auto_mdix_sel} <= lfsr[8:4];
      be = (i % 4 == 3) ? 4'b1101 : 4'b1111;
      lfsr = step(lfsr);
      // the pulse lands before the write returns, so count from before it
      p0 = n_pulse;
      bus(1'b1, 6'h02, {~lfsr, lfsr}, be);
      if (be[0]) ctl[7:0] = lfsr[7:0];
      if (be[1]) ctl[15:8] = lfsr[15:8];
      chk_out(p0, be[1] & lfsr[13]);
      views();
    end
    // corner cases: writes through the aliased views
    p0 = n_pulse;
    bus(1'b1, 6'h04, 32'h0000_FFFF, 4'h3);
    ctl = ctl | 16'hFEE0;
    chk_out(p0, 1);
    views();
    p0 = n_pulse;
    bus(1'b1, 6'h04, 32'h0000_0000, 4'h3);
    ctl = ctl & 16'h011F;
    bus(1'b1, 6'h05, 32'h0000_0000, 4'h3);
    ctl = ctl & 16'hFFE0;
    chk_out(p0, 0);
    views();
    // read-only and unmapped places ignore writes
    bus(1'b1, 6'h06, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, 6'h3F, 32'hFFFF_FFFF, 4'hF);
    rd(6'h3F, 32'h0000_0000);
    views();
    // second reset in mid-run restores defaults
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // outputs must already show the defaults while reset is held
    chk("reset adv_caps", 32'h0000_000F, {28'h000_0000, adv_caps});
    chk("reset adv_pause", 32'h0000_0001, {31'h0, adv_pause});
    chk("reset an_enable", 32'h0000_0001, {31'h0, an_enable});
    chk("reset auto_mdix_en", 32'h0000_0001, {31'h0, auto_mdix_en});
    chk("reset leds", 32'h0000_000F, {28'h000_0000, leds});
    nrst <= 1'b1;
    @(posedge sys_clk);
    ctl = 16'h009F;
    chk_out(n_pulse, 0);
    views();
    results();
  end
endmodule // port_phy_ctrl_tb
`default_nettype wire
